/* File: logic/synth_serial_program_port.sv */
// Purpose: three-wire serial programming port with register file, power and lock mux
// Assumes: serial clock well below system clock, pins asynchronous to I_CLK_SYS
// Notes:   register file is flip-flops indexed by the trailing select field
// What this block does
// RQ1: shift serial data into the shift register on each serial clock rising edge.
// RQ2: words arrive most significant bit first and are read in that order.
// RQ3: last bits shifted before the strobe select the destination register.
// RQ4: strobe rising edge copies shift register into the selected register.
// RQ5: chip enable high powers functions per stored power control bits.
// RQ6: host rewrites the first configuration register after raising chip enable.
// RQ7: push-pull multiplexed output can show the pll lock condition.
// RQ8: host keeps strobe low while shifting and raises it after the last bit.
module synth_serial_program_port
  import synth_spi_pkg::*;
#(
  parameter int WORD_W = synth_spi_pkg::DEF_WORD_W,
  parameter int SEL_W  = synth_spi_pkg::DEF_SEL_W
) (
  input  wire logic                                 I_CLK_SYS,
  input  wire logic                                 I_RESET,
  input  wire logic                                 I_SER_DATA,
  input  wire logic                                 I_SER_CLK,
  input  wire logic                                 I_LATCH_LOAD_STROBE,
  input  wire logic                                 I_CHIP_ENABLE,
  input  wire logic                                 I_PLL_LOCKED,
  output logic                                      O_LOCK_MONITOR_OUTPUT,
  output logic [synth_spi_pkg::PWR_W-1:0]           O_POWER_EN,
  output logic                                      O_RELOCK_PENDING,
  output logic [(2**SEL_W)-1:0][WORD_W-1:0]         O_CFG_REGS
);

  import synth_spi_pkg::*;

  localparam int NUM_REGS = 2**SEL_W;

  if (SEL_W < 1 || SEL_W >= WORD_W) begin : g_bad_sel
    $error("select width must be at least one and below the word width");
  end
  if (PWR_REG_IDX >= NUM_REGS || MUX_REG_IDX >= NUM_REGS) begin : g_bad_idx
    $error("control register index outside the register file");
  end
  if (PWR_LSB + PWR_W > WORD_W || MUX_LSB + MUX_W > WORD_W) begin : g_bad_field
    $error("control field does not fit in the word");
  end

  // pin synchronisation
  pins_type pins_async;
  pins_type pins_s;
  logic [PINS_W-1:0] pins_sync_vec;

  always_comb begin
    pins_async.ser_data          = I_SER_DATA;
    pins_async.ser_clk           = I_SER_CLK;
    pins_async.latch_load_strobe = I_LATCH_LOAD_STROBE;
    pins_async.chip_enable       = I_CHIP_ENABLE;
    pins_async.pll_locked        = I_PLL_LOCKED;
    pins_s                       = pins_type'(pins_sync_vec);
  end

  synth_sync2 #(
    .W (PINS_W)
  ) u_sync (
    .i_clk   (I_CLK_SYS),
    .i_reset (I_RESET),
    .i_async (pins_async),
    .o_sync  (pins_sync_vec)
  );

  // edge history
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic latch_prev_q;
  logic latch_prev_d;
  logic ce_prev_q;
  logic ce_prev_d;
  logic sclk_rise;
  logic latch_rise;
  logic ce_rise;

  always_comb begin
    sclk_prev_d  = pins_s.ser_clk;
    latch_prev_d = pins_s.latch_load_strobe;
    ce_prev_d    = pins_s.chip_enable;
    sclk_rise    = pins_s.ser_clk && !sclk_prev_q;
    latch_rise   = pins_s.latch_load_strobe && !latch_prev_q;
    ce_rise      = pins_s.chip_enable && !ce_prev_q;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      sclk_prev_q  <= 1'b0;
      latch_prev_q <= 1'b0;
      ce_prev_q    <= 1'b0;
    end else begin
      sclk_prev_q  <= sclk_prev_d;
      latch_prev_q <= latch_prev_d;
      ce_prev_q    <= ce_prev_d;
    end
  end

  // shift register
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  logic [SEL_W-1:0]  sel;

  always_comb begin
    shift_d = shift_q;
    if (sclk_rise) begin
      shift_d = {shift_q[WORD_W-2:0], pins_s.ser_data}; // see RQ1 see RQ2
    end
    sel = shift_q[SEL_W-1:0]; // see RQ3
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      shift_q <= {WORD_W{REG_RST_BIT}};
    end else begin
      shift_q <= shift_d;
    end
  end

  // register file
  logic [NUM_REGS-1:0][WORD_W-1:0] regs_q;
  logic [NUM_REGS-1:0][WORD_W-1:0] regs_d;

  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_comb begin
      regs_d[g] = regs_q[g];
      if (latch_rise && (sel == SEL_W'(g))) begin
        regs_d[g] = shift_q; // see RQ4
      end
    end

    always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
        regs_q[g] <= {WORD_W{REG_RST_BIT}};
      end else begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  // power, relock and lock monitor
  logic [PWR_W-1:0] pwr_field;
  logic [PWR_W-1:0] pwr_q;
  logic [PWR_W-1:0] pwr_d;
  logic             relock_q;
  logic             relock_d;
  logic             first_write;
  logic             lock_out_q;
  logic             lock_out_d;
  mux_mode_type     mux_mode;

  always_comb begin
    pwr_field   = regs_q[PWR_REG_IDX][PWR_LSB +: PWR_W];
    pwr_d       = pins_s.chip_enable ? pwr_field : PWR_OFF; // see RQ5
    first_write = latch_rise && (sel == SEL_W'(FIRST_CFG_IDX));
    relock_d    = relock_q;
    if (first_write) begin
      relock_d = 1'b0;
    end
    if (ce_rise) begin
      relock_d = 1'b1; // see RQ6
    end
    mux_mode = mux_mode_type'(regs_q[MUX_REG_IDX][MUX_LSB +: MUX_W]);
    unique case (mux_mode)
      MUX_LOW: begin
        lock_out_d = 1'b0;
      end
      MUX_LOCK: begin
        lock_out_d = pins_s.pll_locked; // see RQ7
      end
      MUX_HIGH: begin
        lock_out_d = 1'b1;
      end
      MUX_RELOCK: begin
        lock_out_d = relock_q;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      pwr_q      <= PWR_OFF;
      relock_q   <= 1'b0;
      lock_out_q <= LOCK_RST;
    end else begin
      pwr_q      <= pwr_d;
      relock_q   <= relock_d;
      lock_out_q <= lock_out_d;
    end
  end

  assign O_LOCK_MONITOR_OUTPUT = lock_out_q;
  assign O_POWER_EN            = pwr_q;
  assign O_RELOCK_PENDING      = relock_q;
  assign O_CFG_REGS            = regs_q;

  // checks
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);

  a_shift_on_edge: assert property ( // see RQ1 see RQ2
    sclk_rise |=> shift_q == WORD_W'({$past(shift_q), $past(pins_s.ser_data)}))
    else $error("shift register did not take data msb first on clock edge");

  a_shift_holds: assert property ( // see RQ1
    !sclk_rise |=> $stable(shift_q))
    else $error("shift register moved without a serial clock edge");

  a_latch_target: assert property ( // see RQ3 see RQ4
    latch_rise |=> regs_q[$past(sel)] == $past(shift_q))
    else $error("strobe did not load the selected register");

  a_latch_only: assert property ( // see RQ4
    !latch_rise |=> $stable(regs_q))
    else $error("register file changed without a strobe edge");

  a_power_off: assert property ( // see RQ5
    !pins_s.chip_enable |=> O_POWER_EN == PWR_OFF)
    else $error("power enables active while chip enable low");

  a_power_follow: assert property ( // see RQ5
    $rose(pins_s.chip_enable) |=> O_POWER_EN == $past(pwr_field))
    else $error("power enables do not follow stored power bits");

  a_lock_mux: assert property ( // see RQ7
    (mux_mode == MUX_LOCK) ##1 (mux_mode == MUX_LOCK)
    |-> O_LOCK_MONITOR_OUTPUT == $past(pins_s.pll_locked))
    else $error("lock monitor does not show pll lock");

  a_relock_flag: assert property ( // see RQ6
    ce_rise |=> O_RELOCK_PENDING)
    else $error("relock flag not set on chip enable rise");

  c_latch_first: cover property (latch_rise && sel == SEL_W'(FIRST_CFG_IDX));
  c_power_up: cover property (ce_rise ##[1:1000] first_write);
  c_lock_shown: cover property (mux_mode == MUX_LOCK ##1 O_LOCK_MONITOR_OUTPUT);

endmodule : synth_serial_program_port

/* File: logic/synth_spi_pkg.sv */
// Purpose: shared constants and types for the synthesizer serial programming port
// Assumes: one system clock; serial pins arrive asynchronously
// Notes:   word length and select width are plain defaults, adjustable by parameter; field positions are fixed
package synth_spi_pkg;

  localparam int       DEF_WORD_W    = 24;
  localparam int       DEF_SEL_W     = 4;
  localparam int       SYNC_STAGES   = 2;
  localparam int       FIRST_CFG_IDX = 0;
  localparam int       PWR_REG_IDX   = 1;
  localparam int       PWR_LSB       = 4;
  localparam int       PWR_W         = 4;
  localparam int       MUX_REG_IDX   = 2;
  localparam int       MUX_LSB       = 4;
  localparam int       MUX_W         = 2;
  localparam logic     REG_RST_BIT   = 1'b0;
  localparam logic     LOCK_RST      = 1'b0;
  localparam logic [PWR_W-1:0] PWR_OFF = 4'h0;

  typedef struct packed {
    logic ser_data;
    logic ser_clk;
    logic latch_load_strobe;
    logic chip_enable;
    logic pll_locked;
  } pins_type;

  localparam int PINS_W = $bits(pins_type);

  typedef enum logic [MUX_W-1:0] {
    MUX_LOW,
    MUX_LOCK,
    MUX_HIGH,
    MUX_RELOCK
  } mux_mode_type;

endpackage : synth_spi_pkg

/* File: logic/synth_sync2.sv */
// Purpose: two-flop synchroniser for a vector of independent asynchronous levels
// Assumes: each bit is a slow level; no bus coherency across bits
// Notes:   first stage feeds only the second stage
module synth_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;

endmodule : synth_sync2

/* File: verification/synth_host_model.sv */
// Purpose: host model driving the three-wire programming pins
// Assumes: pins are sampled by the port's own system clock
// Notes:   serial clock rests low between frames; data then shows the inverse of its last bit
module synth_host_model (
  input  wire logic i_clk,
  output logic      o_data,
  output logic      o_sclk,
  output logic      o_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_data   = 1'b0;
    o_sclk   = 1'b0;
    o_strobe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // one 24-bit word, 400 ns serial clock period
  task automatic send_word(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      o_data <= word[i];
      tick(4);
      o_sclk <= 1'b1;
      tick(4);
      o_sclk <= 1'b0;
    end
    tick(4);
    o_data   <= ~word[0];
    o_strobe <= 1'b1;
    tick(4);
    o_strobe <= 1'b0;
    tick(4);
  endtask : send_word
endmodule : synth_host_model

/* File: verification/synth_serial_program_port_test.sv */
// Purpose: self-checking bench for the serial programming port
// Assumes: default word and select widths
// Notes:   random words to random registers, then power, relock and lock mux modes
module synth_serial_program_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import synth_spi_pkg::*;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    ce = 1'b0;
  logic                    locked = 1'b0;
  logic                    sdata, sclk, strobe, lock_out, relock;
  logic [PWR_W-1:0]        power_en;
  logic [15:0][23:0]       regs;
  logic [23:0]             exp_regs [16];
  logic [31:0]             seed = 32'h0000001E;
  logic [31:0]             r;
  int                      n_errors = 0;
  int                      n_tests = 0;
  int                      cycles = 0;
  always #25 clk = ~clk;
  synth_host_model host (.i_clk(clk), .o_data(sdata), .o_sclk(sclk), .o_strobe(strobe));
  synth_serial_program_port dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_SER_DATA(sdata),
    .I_SER_CLK(sclk), .I_LATCH_LOAD_STROBE(strobe), .I_CHIP_ENABLE(ce),
    .I_PLL_LOCKED(locked), .O_LOCK_MONITOR_OUTPUT(lock_out), .O_POWER_EN(power_en),
    .O_RELOCK_PENDING(relock), .O_CFG_REGS(regs));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic exp_lock(input logic [1:0] m, input logic lk, input logic rp);
    return (m == MUX_LOCK) ? lk : (m == MUX_HIGH) ? 1'b1 : (m == MUX_RELOCK) ? rp : 1'b0;
  endfunction : exp_lock
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [19:0] body, input logic [3:0] sel);
    exp_regs[sel] = {body, sel};
    host.send_word({body, sel});
  endtask : wr
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    foreach (exp_regs[i]) exp_regs[i] = 24'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) check(regs[i], 24'h0);
    check(power_en, 24'h0);
    for (int k = 0; k < 20; k++) begin
      r = rnd();
      wr(r[23:4], (k == 0) ? 4'h0 : (k == 1) ? 4'hF : r[3:0]);
      for (int i = 0; i < 16; i++) check(regs[i], exp_regs[i]);
    end
    r = rnd();
    wr({r[19:4], 4'hA}, 4'h1);
    check(power_en, 24'h0);
    ce <= 1'b1;
    host.tick(6);
    check(power_en, 24'hA);
    check(relock, 24'h1);
    for (int m = 0; m < 4; m++) begin
      wr({r[19:2], m[1:0]}, 4'h2);
      for (int lk = 0; lk < 2; lk++) begin
        locked <= lk[0];
        host.tick(6);
        check(lock_out, exp_lock(m[1:0], lk[0], 1'b1));
      end
    end
    wr(r[23:4], 4'h0);
    check(relock, 24'h0);
    check(lock_out, 24'h0);
    ce <= 1'b0;
    host.tick(6);
    check(power_en, 24'h0);
    for (int i = 0; i < 16; i++) check(regs[i], exp_regs[i]);
    report_and_stop();
  end
endmodule : synth_serial_program_port_test
